// ==== design/mcau_pkg.sv ====
/*
 * Constants and types shared by the monotonic counter authentication unit.
 * Assumes nothing of its surroundings; it is compiled before the design.
 */
package mcau_pkg;

    // ------------------------------------------------------------------
    // Serial opcodes and command types.
    // ------------------------------------------------------------------
    localparam logic [7:0] MCAU_OP_AUTH = 8'h9b;
    localparam logic [7:0] MCAU_OP_READ = 8'h96;
    localparam logic [7:0] MCAU_OP_RST_EN = 8'h66;
    localparam logic [7:0] MCAU_OP_RST = 8'h99;
    localparam logic [7:0] MCAU_CT_ROOT = 8'h00;
    localparam logic [7:0] MCAU_CT_HKEY = 8'h01;
    localparam logic [7:0] MCAU_CT_INC = 8'h02;
    localparam logic [7:0] MCAU_CT_REQ = 8'h03;

    // ------------------------------------------------------------------
    // Widths and frame layout; byte positions count from the opcode.
    // ------------------------------------------------------------------
    localparam int MCAU_NUM_CNT = 4;
    localparam int MCAU_CNT_W = 32;
    localparam int MCAU_KEY_W = 256;
    localparam int MCAU_MSG_W = 64;
    localparam int MCAU_FRAME_BYTES = 40;
    localparam int MCAU_FRAME_BITS = MCAU_FRAME_BYTES * 8;
    localparam int MCAU_LEN_W = 9;
    localparam int MCAU_READ_BITS = 72;
    localparam int MCAU_BYTE_TYPE = 1;
    localparam int MCAU_BYTE_ADDR = 2;
    localparam int MCAU_BYTE_DATA = 4;
    localparam int MCAU_BYTE_KEY = 4;
    localparam int MCAU_BYTE_SIG = 8;

    // ------------------------------------------------------------------
    // Counter status byte fields and reset values.
    // ------------------------------------------------------------------
    localparam int MCAU_ST_BUSY = 0;
    localparam int MCAU_ST_KEYERR = 1;
    localparam int MCAU_ST_SIGERR = 2;
    localparam int MCAU_ST_UNINIT = 3;
    localparam int MCAU_ST_MISMATCH = 4;
    localparam int MCAU_ST_OK = 7;
    localparam logic [7:0] MCAU_STATUS_RST = 8'h00;

    // ------------------------------------------------------------------
    // Software reset lock-out time.
    // ------------------------------------------------------------------
    localparam int MCAU_T_RST_US = 30;
    localparam int MCAU_CLK_MHZ = 50;
    localparam int MCAU_RST_CYC = MCAU_T_RST_US * MCAU_CLK_MHZ;
    localparam int MCAU_RST_CNT_W = 11;

    // Command sequencer states.
    typedef enum logic [1:0] {S_IDLE, S_DERIVE, S_VERIFY} mcau_state_e;

endpackage

// ==== design/mcau_top.sv ====
/*
 * Monotonic counter authentication unit: serial front end on the link
 * clock, command sequencer, counters and keys on the system clock.
 * Assumes an external keyed-hash engine on clk_sys and a host that frames
 * every command with cs_b and stops spi_clk between frames.
 */
// Contract
// RQ1: Four 32-bit counters chosen by address byte.
// RQ2: Commands checked with keyed SHA-256 hash result.
// RQ3: Root key write stores key, zeroes counters.
// RQ4: Provisioned root key never rewritten nor sent.
// RQ5: Host loads HMAC key after each power-on.
// RQ6: Accepted increment adds exactly one.
// RQ7: Accepted request exposes counter value unchanged.
// RQ8: Authenticated opcode acts only after authentication; the root key write is stored without any hash check.
// RQ9: Status bit zero high while operation runs.
// RQ10: Only software reset aborts running operation.
// RQ11: Array read, program, erase stay accepted.
// RQ12: Flash status words stay usable meanwhile.
// RQ13: New authenticated command ignored while busy.
// RQ14: Authenticated command works during array work.
// RQ15: Status read returns status byte anytime.
// RQ16: Host discards data while busy bit set.
// RQ17: Status read works during array program/erase.
// RQ18: Software reset anytime clears volatile state.
// RQ19: Enable-reset then reset, then thirty microsecond lockout.
// RQ20: Bit seven marks error-free completion.
// RQ21: Status untouched before eight command bits.
// RQ22: Failed signature leaves counters and keys unchanged.
module mcau_top #(
    parameter int NUM_CNT = mcau_pkg::MCAU_NUM_CNT
) (
    // System clock and power-on reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Serial link from the host controller.
    input wire logic spi_clk,
    input wire logic cs_b,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Keyed-hash engine.
    output logic hash_start,
    output logic [mcau_pkg::MCAU_KEY_W-1:0] hash_key,
    output logic [mcau_pkg::MCAU_MSG_W-1:0] hash_msg,
    input wire logic hash_done,
    input wire logic [mcau_pkg::MCAU_KEY_W-1:0] hash_result,
    // Device-wide indications.
    output logic soft_reset,
    output logic busy
);
    import mcau_pkg::*;

    // ------------------------------------------------------------------
    // Local constants.
    // ------------------------------------------------------------------
    localparam int IDX_W = $clog2(NUM_CNT);
    localparam logic [7:0] CNT_LIMIT = 8'(NUM_CNT);
    localparam logic [MCAU_LEN_W-1:0] LEN_FULL = MCAU_LEN_W'(MCAU_FRAME_BITS);
    localparam logic [MCAU_LEN_W-1:0] LEN_OP = MCAU_LEN_W'(8);
    localparam logic [MCAU_LEN_W-1:0] LEN_MAX = '1;
    localparam logic [MCAU_RST_CNT_W-1:0] RST_LOAD =
        MCAU_RST_CNT_W'(MCAU_RST_CYC);
    localparam int TOP = MCAU_FRAME_BITS - 1;

    // ------------------------------------------------------------------
    // Link domain: frame capture and read-out.
    // ------------------------------------------------------------------
    logic link_clr; // Clears the per-frame link state between frames.
    logic [MCAU_LEN_W-1:0] bit_cnt; // Bits seen in the current frame.
    logic [MCAU_LEN_W-1:0] frame_len; // Bit count of the latest frame.
    logic [MCAU_FRAME_BITS-1:0] frame_sh; // Received bits, newest at LSB.
    logic [7:0] op_byte; // First byte of the latest frame.
    logic [MCAU_READ_BITS-1:0] out_sh; // Read-out shifter.
    logic rd_active; // Read-out in progress in this frame.

    // Per-frame state is cleared whenever the chip is deselected, so each
    // frame starts counting from zero with no edge needed beforehand.
    assign link_clr = cs_b | ~rst_b;

    // Bit counter, saturating so an overlong frame cannot wrap to a legal
    // length.
    always_ff @(posedge spi_clk or posedge link_clr) begin
        if (link_clr) begin
            bit_cnt <= '0;
        end else if (bit_cnt != LEN_MAX) begin
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    // Frame contents. These are not cleared by deselect: the system side
    // reads them after the frame, while spi_clk stands still.
    always_ff @(posedge spi_clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_sh <= '0;
            frame_len <= '0;
            op_byte <= '0;
        end else begin
            frame_sh <= {frame_sh[TOP-1:0], mosi};
            frame_len <= (bit_cnt == LEN_MAX) ? LEN_MAX : bit_cnt + 1'b1;
            if (bit_cnt == LEN_OP - 1'b1) begin
                op_byte <= {frame_sh[6:0], mosi};
            end
        end
    end

    logic [MCAU_READ_BITS-1:0] rd_image; // Status and data, system side.

    // Read-out drives on falling edges. The image is loaded right after
    // the opcode; it is frozen on the system side while cs_b is low.
    always_ff @(negedge spi_clk or posedge link_clr) begin
        if (link_clr) begin
            out_sh <= '0;
            rd_active <= 1'b0;
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end else if (bit_cnt == LEN_OP && op_byte == MCAU_OP_READ) begin
            // Status byte is answered at any time, busy or not. RQ15 RQ17
            out_sh <= {rd_image[MCAU_READ_BITS-2:0], 1'b0};
            miso <= rd_image[MCAU_READ_BITS-1];
            miso_oe <= 1'b1;
            rd_active <= 1'b1;
        end else if (rd_active) begin
            out_sh <= {out_sh[MCAU_READ_BITS-2:0], 1'b0};
            miso <= out_sh[MCAU_READ_BITS-1];
            miso_oe <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Crossing: chip select level into the system domain.
    // ------------------------------------------------------------------
    logic cs_meta; // First stage, read only by cs_sync.
    logic cs_sync; // Synchronised deselect level.
    logic cs_prev; // Delayed copy for edge detection.
    logic frame_end; // One-cycle pulse after each frame.

    // Two-stage synchroniser plus an edge detector on the second stage.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= cs_b;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end
    assign frame_end = cs_sync & ~cs_prev;

    // ------------------------------------------------------------------
    // Frame decode and software reset.
    // ------------------------------------------------------------------
    logic [MCAU_RST_CNT_W-1:0] rst_cnt; // Lock-out after software reset.
    logic rst_armed; // Enable-reset was the previous frame.
    logic rx_valid; // A frame with a full opcode may be acted on.
    logic do_reset; // Software reset sequence completed.
    logic auth_go; // Authenticated command accepted for processing.
    mcau_state_e state;

    // Frames shorter than one opcode never touch the status. RQ21
    // Only this unit's opcodes are decoded; all other frames, array and
    // flash status commands among them, pass by untouched. RQ11 RQ12
    assign rx_valid = frame_end && rst_cnt == '0 && frame_len >= LEN_OP;
    assign do_reset = rx_valid && op_byte == MCAU_OP_RST && rst_armed;
    // A second authenticated command is dropped while one runs. RQ13 RQ14
    assign auth_go = rx_valid && op_byte == MCAU_OP_AUTH && state == S_IDLE;

    // Enable-reset arms; any other frame with a full opcode disarms. RQ19
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_armed <= 1'b0;
        end else if (rx_valid) begin
            rst_armed <= (op_byte == MCAU_OP_RST_EN);
        end
    end

    // No frame is accepted during the reset period. RQ19
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_cnt <= '0;
        end else if (do_reset) begin
            rst_cnt <= RST_LOAD;
        end else if (rst_cnt != '0) begin
            rst_cnt <= rst_cnt - 1'b1;
        end
    end

    // The reset pulse also tells the rest of the device to drop its
    // volatile settings. RQ18
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= do_reset;
        end
    end

    // ------------------------------------------------------------------
    // Command sequencer, keys and counters.
    // ------------------------------------------------------------------
    logic [7:0] f_type; // Command type of the received frame.
    logic [7:0] f_addr; // Counter address of the received frame.
    logic [MCAU_CNT_W-1:0] f_data; // Data word of the received frame.
    logic [MCAU_KEY_W-1:0] f_sig; // Signature of the received frame.
    logic [MCAU_KEY_W-1:0] f_key; // Root key field of the received frame.
    assign f_type = frame_sh[TOP-8*MCAU_BYTE_TYPE -: 8];
    assign f_addr = frame_sh[TOP-8*MCAU_BYTE_ADDR -: 8];
    assign f_data = frame_sh[TOP-8*MCAU_BYTE_DATA -: MCAU_CNT_W];
    assign f_sig = frame_sh[TOP-8*MCAU_BYTE_SIG -: MCAU_KEY_W];
    assign f_key = frame_sh[TOP-8*MCAU_BYTE_KEY -: MCAU_KEY_W];

    logic [7:0] cmd_type; // Latched type; the frame buffer may move on.
    logic [IDX_W-1:0] cmd_idx; // Latched counter index.
    logic [MCAU_CNT_W-1:0] cmd_data; // Latched data word.
    logic [MCAU_KEY_W-1:0] cmd_sig; // Latched signature.
    logic [MCAU_KEY_W-1:0] root_key; // Write-once root key.
    logic root_set; // Root key provisioned.
    logic [MCAU_KEY_W-1:0] hmac_key; // Session key, volatile.
    logic hmac_ok; // Session key loaded since power-on or reset.
    logic [MCAU_KEY_W-1:0] derived; // Candidate session key.
    logic [MCAU_CNT_W-1:0] counter [NUM_CNT]; // The monotonic counters.
    logic [7:1] status; // Result bits of the status byte.
    logic [MCAU_CNT_W-1:0] rd_tag; // Tag echoed with a request.
    logic [MCAU_CNT_W-1:0] rd_value; // Counter value for read-out.

    // Returns the result bits 7:1 of a status byte with only one of them set.
    function automatic logic [7:1] flag(input int pos);
        logic [7:0] v;
        v = 8'h00;
        v[pos] = 1'b1;
        return v[7:1];
    endfunction

    // Main sequencer. Apart from the root key write, which is not hashed, nothing
    // changes a counter or a key before the hash matches; a mismatch only reports through the status. RQ8 RQ22
    // Only the software reset leaves a running command early. RQ10
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_IDLE;
            status <= MCAU_STATUS_RST[7:1];
            hash_start <= 1'b0;
            hash_key <= '0;
            hash_msg <= '0;
            cmd_type <= '0;
            cmd_idx <= '0;
            cmd_data <= '0;
            cmd_sig <= '0;
            root_key <= '0;
            root_set <= 1'b0;
            hmac_key <= '0;
            hmac_ok <= 1'b0;
            derived <= '0;
            rd_tag <= '0;
            rd_value <= '0;
            for (int i = 0; i < NUM_CNT; i++) begin
                counter[i] <= '0;
            end
        end else if (do_reset) begin
            // Sequencer state, status and the session key flag return to power-on
            // values; counters, the root key and the read-out data are kept. RQ18
            state <= S_IDLE;
            status <= MCAU_STATUS_RST[7:1];
            hash_start <= 1'b0;
            hmac_ok <= 1'b0;
        end else begin
            hash_start <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (auth_go) begin
                        cmd_type <= f_type;
                        cmd_idx <= f_addr[IDX_W-1:0];
                        cmd_data <= f_data;
                        cmd_sig <= f_sig;
                        hash_msg <= frame_sh[TOP-8 -: MCAU_MSG_W];
                        if (frame_len != LEN_FULL) begin
                            status <= flag(MCAU_ST_SIGERR);
                        end else if (f_type == MCAU_CT_ROOT) begin
                            if (root_set) begin
                                // Root key is write-once. RQ4
                                status <= flag(MCAU_ST_KEYERR);
                            end else begin
                                // Store the key and zero every counter. RQ3
                                root_key <= f_key;
                                root_set <= 1'b1;
                                for (int i = 0; i < NUM_CNT; i++) begin
                                    counter[i] <= '0;
                                end
                                status <= flag(MCAU_ST_OK); // RQ20
                            end
                        end else if (f_type == MCAU_CT_HKEY) begin
                            if (!root_set) begin
                                status <= flag(MCAU_ST_UNINIT);
                            end else begin
                                // New session key from the root key. RQ2
                                hash_key <= root_key;
                                hash_start <= 1'b1;
                                state <= S_DERIVE;
                            end
                        end else if (f_type == MCAU_CT_INC ||
                                     f_type == MCAU_CT_REQ) begin
                            if (!hmac_ok) begin
                                // The host skipped the key update. RQ5
                                status <= flag(MCAU_ST_UNINIT);
                            end else if (f_addr >= CNT_LIMIT) begin
                                status <= flag(MCAU_ST_SIGERR); // RQ1
                            end else begin
                                hash_key <= hmac_key; // RQ2
                                hash_start <= 1'b1;
                                state <= S_VERIFY;
                            end
                        end else begin
                            status <= flag(MCAU_ST_SIGERR);
                        end
                    end
                end
                S_DERIVE: begin
                    // Second hash checks the frame with the candidate key.
                    if (hash_done) begin
                        derived <= hash_result;
                        hash_key <= hash_result;
                        hash_start <= 1'b1;
                        state <= S_VERIFY;
                    end
                end
                S_VERIFY: begin
                    if (hash_done) begin
                        state <= S_IDLE;
                        if (hash_result != cmd_sig) begin
                            status <= flag(MCAU_ST_SIGERR); // RQ22
                        end else if (cmd_type == MCAU_CT_HKEY) begin
                            hmac_key <= derived;
                            hmac_ok <= 1'b1;
                            status <= flag(MCAU_ST_OK); // RQ20
                        end else if (cmd_type == MCAU_CT_INC) begin
                            if (cmd_data != counter[cmd_idx]) begin
                                status <= flag(MCAU_ST_MISMATCH);
                            end else begin
                                counter[cmd_idx] <=
                                    counter[cmd_idx] + 1'b1; // RQ6
                                status <= flag(MCAU_ST_OK); // RQ20
                            end
                        end else begin
                            // Value copied out, counter left alone. RQ7
                            rd_tag <= cmd_data;
                            rd_value <= counter[cmd_idx];
                            status <= flag(MCAU_ST_OK); // RQ20
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Busy follows the sequencer: high from acceptance to result. RQ9
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else if (do_reset) begin
            busy <= 1'b0;
        end else begin
            busy <= (state != S_IDLE) || (auth_go && frame_len == LEN_FULL &&
                (f_type == MCAU_CT_HKEY ? root_set :
                 (f_type == MCAU_CT_INC || f_type == MCAU_CT_REQ) &&
                 hmac_ok && f_addr < CNT_LIMIT));
        end
    end

    // Read-out image, refreshed only between frames so the link side
    // never sees it change mid-shift. The root key is never part of it.
    // Data is only meaningful while the busy bit reads zero. RQ4 RQ16
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_image <= '0;
        end else if (cs_sync) begin
            rd_image <= {status, busy, rd_tag, rd_value};
        end
    end

endmodule

// ==== bench/mcau_host.sv ====
/*
 * Host controller model: mode-0 frames, link clock stopped between frames.
 * Assumes the bench calls xfer only after reset has been released.
 */
module mcau_host (
    // Serial link.
    output logic spi_clk,
    output logic cs_b,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        spi_clk = 1'b0;
        cs_b = 1'b1;
        mosi = 1'b0;
    end

    // Sends n bits MSB first and keeps the last 72 bits seen on miso.
    // The data line is inverted after a frame so a stale bit never helps.
    task automatic xfer(input logic [319:0] d, input int n,
                        output logic [71:0] q);
        q = '0;
        cs_b = 1'b0;
        #32;
        for (int i = 0; i < n; i++) begin
            mosi = d[319-i];
            #32 spi_clk = 1'b1;
            q = {q[70:0], miso};
            #32 spi_clk = 1'b0;
        end
        #32 cs_b = 1'b1;
        mosi = ~mosi;
        #400;
    endtask
endmodule

// ==== bench/mcau_top_assertions.sv ====
/*
 * Port checker for mcau_top, bound to every instance.
 * Assumes the system clock domain for all checks.
 */
module mcau_top_assertions #(
    parameter int NUM_CNT = 4
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic miso_oe,
    input wire logic hash_start,
    input wire logic hash_done,
    input wire logic soft_reset,
    input wire logic busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_busy_on; hash_start |-> busy; endproperty
    a_busy_on: assert property (p_busy_on)
        else $error("busy low while hash starts");
    property p_busy_hold;
        busy && !hash_done && !$past(hash_done) |=> busy || soft_reset;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped without completion");
    property p_busy_cause; $rose(busy) |-> hash_start; endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy rose without a hash start");
    property p_start_pulse; hash_start |=> !hash_start; endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("hash start longer than one cycle");
    property p_busy_end;
        $fell(busy) |-> $past(hash_done) || $past(hash_done, 2) ||
            $past(hash_done, 3) || soft_reset || $past(soft_reset);
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("busy fell with no hash result");
    property p_sr_pulse; soft_reset |=> !soft_reset; endproperty
    a_sr_pulse: assert property (p_sr_pulse)
        else $error("soft reset longer than one cycle");
    property p_sr_lock; soft_reset && !busy |=> !hash_start[*8]; endproperty
    a_sr_lock: assert property (p_sr_lock)
        else $error("command run during reset lockout");
    property p_oe_idle; cs_b && $past(cs_b) |-> !miso_oe; endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("miso driven while deselected");
endmodule

bind mcau_top mcau_top_assertions #(.NUM_CNT(NUM_CNT)) u_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b), .miso_oe(miso_oe),
    .hash_start(hash_start), .hash_done(hash_done),
    .soft_reset(soft_reset), .busy(busy));

// ==== bench/mcau_top_tb.sv ====
/*
 * Self-checking bench: host model on the link, hash engine model here
 * that answers hlat cycles after a start with the inverted key.
 */
module mcau_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mcau_pkg::*;
    logic clk_sys = 0, rst_b = 0, hash_done = 0, sr_seen = 0;
    logic spi_clk, cs_b, mosi, miso, miso_oe, hash_start, soft_reset, busy;
    logic [255:0] hash_key, hash_result = '0, root = {8{32'hc3a5_1e07}};
    logic [63:0] hash_msg;
    logic [71:0] q;
    int err_count = 0, tests_run = 0, hlat = 4, hcnt = 0;

    always #10 clk_sys = ~clk_sys;

    mcau_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .spi_clk(spi_clk),
        .cs_b(cs_b), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .hash_start(hash_start), .hash_key(hash_key), .hash_msg(hash_msg),
        .hash_done(hash_done), .hash_result(hash_result),
        .soft_reset(soft_reset), .busy(busy));
    mcau_host u_host (.spi_clk(spi_clk), .cs_b(cs_b), .mosi(mosi),
        .miso(miso));

    // Engine model; with the inverted key every valid signature is root.
    always @(posedge clk_sys) begin
        hash_done <= (hcnt == 1);
        if (hash_start) begin
            hcnt <= hlat;
            hash_result <= ~hash_key;
        end else if (hcnt != 0)
            hcnt <= hcnt - 1;
        if (soft_reset)
            sr_seen <= 1'b1;
    end

    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic rd;
        u_host.xfer({MCAU_OP_READ, 312'h0}, 80, q);
    endtask
    // Data is trusted only once the busy bit reads clear.
    task automatic poll;
        for (int i = 0; i < 40; i++) begin
            rd();
            if (q[64] === 1'b0)
                return;
        end
        err_count++;
        stop_test();
    endtask
    task automatic send(input logic [7:0] ty, ad, input logic [31:0] d,
                        input logic [255:0] s);
        u_host.xfer({MCAU_OP_AUTH, ty, ad, 8'h00, d, s}, 320, q);
    endtask
    task automatic op(input logic [7:0] ty, ad, input logic [31:0] d,
                      input logic [255:0] s, input logic [7:0] e);
        send(ty, ad, d, s);
        poll();
        chk(72'(q[71:64]), 72'(e));
    endtask
    task automatic req(input logic [7:0] ad, input logic [31:0] v);
        op(MCAU_CT_REQ, ad, 32'h1234_5678, root, 8'h80);
        chk(q, {8'h80, 32'h1234_5678, v});
        // The hashed message starts at the type byte of the frame.
        chk(72'(hash_msg), 72'({MCAU_CT_REQ, ad, 8'h00, 32'h1234_5678,
            root[255:248]}));
    endtask

    task automatic t_prov;
        rd();
        chk(72'(q[71:64]), 72'h0);
        op(MCAU_CT_ROOT, 0, root[255:224], {root[223:0], 32'h0}, 8'h80);
        op(MCAU_CT_INC, 0, 0, root, 8'h08);
        // Counter requests are only legal once the session key is loaded.
        op(MCAU_CT_HKEY, 0, 0, root, 8'h80);
        req(8'h00, 32'h0);
        op(MCAU_CT_ROOT, 0, 0, 0, 8'h02);
    endtask
    task automatic t_count;
        op(MCAU_CT_INC, 0, 0, ~root, 8'h04);
        req(8'h00, 32'h0);
        op(MCAU_CT_INC, 0, 0, root, 8'h80);
        req(8'h00, 32'h1);
        req(8'h00, 32'h1);
        op(MCAU_CT_INC, 3, 0, root, 8'h80);
        req(8'h03, 32'h1);
    endtask
    task automatic t_busy;
        hlat = 2000;
        send(MCAU_CT_INC, 0, 1, root);
        rd();
        chk(72'(q[64]), 72'h1);
        // A foreign opcode while busy must neither stall nor disturb us.
        u_host.xfer({8'h05, 312'h0}, 16, q);
        rd();
        chk(72'(q[71:64]), 72'h81);
        send(MCAU_CT_INC, 0, 2, root);
        poll();
        hlat = 4;
        req(8'h00, 32'h2);
    endtask
    task automatic t_reset;
        u_host.xfer({MCAU_OP_RST_EN, 312'h0}, 8, q);
        u_host.xfer({MCAU_OP_RST, 312'h0}, 8, q);
        chk(72'(sr_seen), 72'h1);
        repeat (1600) @(posedge clk_sys);
        rd();
        chk(72'(q[71:64]), 72'h0);
        op(MCAU_CT_INC, 0, 2, root, 8'h08);
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_prov();
        t_count();
        t_busy();
        t_reset();
        stop_test();
    end
endmodule
